// ---- shared/fpw_pkg.sv ----
package fpw_pkg;
    // Flash size variants
    typedef enum logic [2:0] {
        FPW_V16K   = 3'b000,
        FPW_V32KE  = 3'b001,  // Even-page 32 KB variant, no low window mapping
        FPW_V32KO  = 3'b010,  // Odd-page 32 KB variant
        FPW_V64K   = 3'b011,
        FPW_V96K   = 3'b100,
        FPW_V128K  = 3'b101
    } fpw_variant_t;

    // Window bounds, upper two address bits
    localparam logic [1:0] LOW_WIN   = 2'h0;  // 0x0000-0x3FFF
    localparam logic [1:0] MID_WIN   = 2'h1;  // 0x4000-0x7FFF
    localparam logic [1:0] PAGED_WIN = 2'h2;  // 0x8000-0xBFFF
    localparam logic [1:0] TOP_WIN   = 2'h3;  // 0xC000-0xFFFF

    // Fixed pages
    localparam logic [5:0] PAGE_3F = 6'h3f;
    localparam logic [5:0] PAGE_3E = 6'h3e;
    localparam logic [5:0] PAGE_3D = 6'h3d;
    localparam logic [5:0] PAGE_3C = 6'h3c;
    localparam logic [5:0] PAGE_38 = 6'h38;

    // Reset values
    localparam logic [5:0] PAGE_SEL_RST = 6'h00;
    localparam logic [21:0] FLASH_ADDR_RST = 22'h000000;

    // Decode result to the flash array
    typedef struct packed {
        logic        hit;
        logic [5:0]  page;
        logic [13:0] offset;
    } fpw_flash_req_t;
endpackage

// ---- src/fpw_mapper.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - No paging off-chip; internal flash only
// - Paged window reaches page chosen by select
// - Map enable shows page 3F at top
// - Page 3E mid window unless half-map or the 16K variant
// - Page 3D low window except one variant
// - Select values alias by low bits; values landing on absent pages miss
module fpw_mapper (
    // Clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RST,
    // Configuration
    input  wire fpw_pkg::fpw_variant_t   VARIANT,
    input  wire logic                    FLASH_MAP_ENABLE,
    input  wire logic                    FLASH_HALF_MAP_CONTROL,
    // Page select load
    input  wire logic                    PAGE_SEL_WE,
    input  wire logic [5:0]              PAGE_SEL_DATA,
    output logic [5:0]                   PROGRAM_PAGE_SELECT,
    // CPU address bus
    input  wire logic                    CPU_VALID,
    input  wire logic [15:0]             CPU_ADDR,
    // Flash array request
    output fpw_pkg::fpw_flash_req_t      FLASH_REQ
);
    logic [5:0]               program_page_select_reg;
    fpw_pkg::fpw_flash_req_t  flash_req_reg;
    fpw_pkg::fpw_flash_req_t  flash_req_next;
    logic                     paged_hit;
    logic [5:0]               paged_page;

    // Select value to page for the paged window; upper select bits are not decoded
    function automatic logic [5:0] alias_page(input fpw_pkg::fpw_variant_t v,
                                              input logic [5:0]            sel);
        logic [5:0] pg;
        pg = fpw_pkg::PAGE_3F;
        case (v)
            fpw_pkg::FPW_V16K: begin
                pg = fpw_pkg::PAGE_3F;
            end
            fpw_pkg::FPW_V32KE, fpw_pkg::FPW_V32KO: begin
                pg = sel[0] ? fpw_pkg::PAGE_3F : fpw_pkg::PAGE_3E;
            end
            fpw_pkg::FPW_V64K: begin
                pg = {fpw_pkg::PAGE_3C[5:2], sel[1:0]};
            end
            fpw_pkg::FPW_V96K, fpw_pkg::FPW_V128K: begin
                pg = {fpw_pkg::PAGE_38[5:3], sel[2:0]};
            end
            default: begin
                pg = fpw_pkg::PAGE_3F;
            end
        endcase
        return pg;
    endfunction

    // Whether a select value lands on a page that this variant implements
    function automatic logic alias_hit(input fpw_pkg::fpw_variant_t v,
                                       input logic [5:0]            sel);
        logic hit;
        hit = 1'b0;
        case (v)
            fpw_pkg::FPW_V16K: begin
                hit = sel[0];
            end
            fpw_pkg::FPW_V32KE, fpw_pkg::FPW_V32KO: begin
                hit = 1'b1;
            end
            fpw_pkg::FPW_V64K: begin
                hit = sel[2];
            end
            fpw_pkg::FPW_V96K: begin
                hit = (sel[2:0] >= 3'h2);                          // Pages 38, 39 absent
            end
            fpw_pkg::FPW_V128K: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // Paged window decode from the current select value
    assign paged_hit  = alias_hit(VARIANT, program_page_select_reg);
    assign paged_page = alias_page(VARIANT, program_page_select_reg);

    // Page select register, loaded by software before window use
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            program_page_select_reg <= fpw_pkg::PAGE_SEL_RST;
        end else if (PAGE_SEL_WE) begin
            program_page_select_reg <= PAGE_SEL_DATA;
        end
    end

    // Window decode
    always_comb begin
        flash_req_next.hit    = 1'b0;
        flash_req_next.page   = fpw_pkg::PAGE_3F;
        flash_req_next.offset = CPU_ADDR[13:0];
        if (CPU_VALID && FLASH_MAP_ENABLE) begin
            case (CPU_ADDR[15:14])
                fpw_pkg::TOP_WIN: begin
                    flash_req_next.hit = 1'b1;
                end
                fpw_pkg::MID_WIN: begin
                    flash_req_next.hit  = !FLASH_HALF_MAP_CONTROL
                                        && (VARIANT != fpw_pkg::FPW_V16K);
                    flash_req_next.page = fpw_pkg::PAGE_3E;
                end
                fpw_pkg::LOW_WIN: begin
                    flash_req_next.hit  = (VARIANT != fpw_pkg::FPW_V32KE);
                    flash_req_next.page = fpw_pkg::PAGE_3D;
                end
                fpw_pkg::PAGED_WIN: begin
                    flash_req_next.hit  = paged_hit;
                    flash_req_next.page = paged_page;
                end
                default: begin
                    flash_req_next.hit = 1'b0;
                end
            endcase
        end
    end

    // Registered request to the flash array; no page bits leave the chip
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            flash_req_reg <= '0;
        end else begin
            flash_req_reg <= flash_req_next;
        end
    end

    assign PROGRAM_PAGE_SELECT = program_page_select_reg;
    assign FLASH_REQ           = flash_req_reg;

    // Top window shows the last page while the map is on
    chk_top_window_hit: assert property (@(posedge CLK) disable iff (RST)
        (CPU_VALID && FLASH_MAP_ENABLE && CPU_ADDR[15:14] == fpw_pkg::TOP_WIN)
        |=> (FLASH_REQ.hit && FLASH_REQ.page == fpw_pkg::PAGE_3F))
        else $error("top window did not map page 3F");

    // Map off: nothing reaches flash
    chk_map_off_miss: assert property (@(posedge CLK) disable iff (RST)
        !FLASH_MAP_ENABLE |=> !FLASH_REQ.hit)
        else $error("flash hit while map disabled");

    // Middle window hit follows half-map control and variant
    chk_mid_half_map: assert property (@(posedge CLK) disable iff (RST)
        (CPU_VALID && FLASH_MAP_ENABLE && CPU_ADDR[15:14] == fpw_pkg::MID_WIN)
        |=> (FLASH_REQ.hit == ($past(!FLASH_HALF_MAP_CONTROL)
             && $past(VARIANT) != fpw_pkg::FPW_V16K)))
        else $error("middle window mapping wrong");

    // Middle window hit carries the second-to-last page
    chk_mid_window_page: assert property (@(posedge CLK) disable iff (RST)
        (CPU_VALID && FLASH_MAP_ENABLE && CPU_ADDR[15:14] == fpw_pkg::MID_WIN
         && !FLASH_HALF_MAP_CONTROL && VARIANT != fpw_pkg::FPW_V16K)
        |=> (FLASH_REQ.hit && FLASH_REQ.page == fpw_pkg::PAGE_3E))
        else $error("middle window page wrong");

    // Low window shows page 3D except on one variant
    chk_low_window_map: assert property (@(posedge CLK) disable iff (RST)
        (CPU_VALID && FLASH_MAP_ENABLE && CPU_ADDR[15:14] == fpw_pkg::LOW_WIN)
        |=> (FLASH_REQ.hit == ($past(VARIANT) != fpw_pkg::FPW_V32KE)
             && FLASH_REQ.page == fpw_pkg::PAGE_3D))
        else $error("low window mapping wrong");

    // A load shows on the select one cycle later
    chk_page_load: assert property (@(posedge CLK) disable iff (RST)
        PAGE_SEL_WE |=> PROGRAM_PAGE_SELECT == $past(PAGE_SEL_DATA))
        else $error("page select not loaded");

    // Select keeps its value between loads
    chk_select_hold: assert property (@(posedge CLK) disable iff (RST)
        !PAGE_SEL_WE |=> $stable(PROGRAM_PAGE_SELECT))
        else $error("page select changed without a load");

    // Largest variant: every select value hits
    chk_alias_128k: assert property (@(posedge CLK) disable iff (RST)
        (CPU_VALID && FLASH_MAP_ENABLE && CPU_ADDR[15:14] == fpw_pkg::PAGED_WIN
         && VARIANT == fpw_pkg::FPW_V128K)
        |=> (FLASH_REQ.hit && FLASH_REQ.page == {fpw_pkg::PAGE_38[5:3], $past(PROGRAM_PAGE_SELECT[2:0])}))
        else $error("128K alias wrong");

    // Single-page variant: odd values only
    chk_alias_16k: assert property (@(posedge CLK) disable iff (RST)
        (CPU_VALID && FLASH_MAP_ENABLE && CPU_ADDR[15:14] == fpw_pkg::PAGED_WIN
         && VARIANT == fpw_pkg::FPW_V16K)
        |=> (FLASH_REQ.hit == $past(PROGRAM_PAGE_SELECT[0])
             && (!FLASH_REQ.hit || FLASH_REQ.page == fpw_pkg::PAGE_3F)))
        else $error("16K alias wrong");

    // Two-page variants: even to 3E, odd to 3F
    chk_alias_32k: assert property (@(posedge CLK) disable iff (RST)
        (CPU_VALID && FLASH_MAP_ENABLE && CPU_ADDR[15:14] == fpw_pkg::PAGED_WIN
         && (VARIANT == fpw_pkg::FPW_V32KE || VARIANT == fpw_pkg::FPW_V32KO))
        |=> (FLASH_REQ.hit && FLASH_REQ.page == ($past(PROGRAM_PAGE_SELECT[0])
             ? fpw_pkg::PAGE_3F : fpw_pkg::PAGE_3E)))
        else $error("32K alias wrong");

    // Four-page variant: bit 2 set picks 3C to 3F
    chk_alias_64k: assert property (@(posedge CLK) disable iff (RST)
        (CPU_VALID && FLASH_MAP_ENABLE && CPU_ADDR[15:14] == fpw_pkg::PAGED_WIN
         && VARIANT == fpw_pkg::FPW_V64K)
        |=> (FLASH_REQ.hit == $past(PROGRAM_PAGE_SELECT[2]) && (!FLASH_REQ.hit
             || FLASH_REQ.page == {fpw_pkg::PAGE_3C[5:2], $past(PROGRAM_PAGE_SELECT[1:0])})))
        else $error("64K alias wrong");

    // Six-page variant: low bits 2 to 7 pick 3A to 3F
    chk_alias_96k: assert property (@(posedge CLK) disable iff (RST)
        (CPU_VALID && FLASH_MAP_ENABLE && CPU_ADDR[15:14] == fpw_pkg::PAGED_WIN
         && VARIANT == fpw_pkg::FPW_V96K)
        |=> (FLASH_REQ.hit == ($past(PROGRAM_PAGE_SELECT[2:0]) >= 3'h2) && (!FLASH_REQ.hit
             || FLASH_REQ.page == {fpw_pkg::PAGE_38[5:3], $past(PROGRAM_PAGE_SELECT[2:0])})))
        else $error("96K alias wrong");

    // Only a valid access reaches flash
    chk_idle_no_hit: assert property (@(posedge CLK) disable iff (RST)
        !CPU_VALID |=> !FLASH_REQ.hit)
        else $error("flash hit without a valid access");

    // Offset within the page passes straight through
    chk_offset_pass: assert property (@(posedge CLK) disable iff (RST)
        CPU_VALID |=> FLASH_REQ.offset == $past(CPU_ADDR[13:0]))
        else $error("offset not passed");
endmodule // fpw_mapper

// ---- testbench/fpw_flash_model.sv ----
`timescale 1ns/1ps
module fpw_flash_model (
    // Decoder request and read data
    input  wire logic                    CLK,
    input  wire fpw_pkg::fpw_flash_req_t REQ,
    output logic [15:0]                  DATA
);
    // Internal array only; a miss leaves the data bus floating, shown inverted
    always_ff @(posedge CLK) begin
        DATA <= REQ.hit ? {REQ.page[1:0], REQ.offset} : ~DATA;
    end
endmodule // fpw_flash_model

// ---- testbench/fpw_mapper_test.sv ----
`timescale 1ns/1ps
module fpw_mapper_test;
    logic                    clk = 0, rst = 1, en = 0, hm = 0, we = 0, valid = 0;
    logic [5:0]              sel = 6'h00, data = 6'h00, sel_q;
    logic [15:0]             addr = 16'h0000, flash_data;
    fpw_pkg::fpw_variant_t   v = fpw_pkg::FPW_V16K;
    fpw_pkg::fpw_flash_req_t req;
    int                      n_errors = 0, comparisons = 0, cyc = 0;
    fpw_mapper fpw_mapper_i (.CLK(clk), .RST(rst), .VARIANT(v), .FLASH_MAP_ENABLE(en),
        .FLASH_HALF_MAP_CONTROL(hm), .PAGE_SEL_WE(we), .PAGE_SEL_DATA(data),
        .PROGRAM_PAGE_SELECT(sel_q), .CPU_VALID(valid), .CPU_ADDR(addr), .FLASH_REQ(req));
    fpw_flash_model fpw_flash_model_i (.CLK(clk), .REQ(req), .DATA(flash_data));
    // Clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            test_done;
        end
    end
    // Expected hit and page for one window
    function automatic logic [6:0] exp_f(logic [1:0] w);
        if (!en || !valid) return 7'h00;
        case (w)
            2'h3: return 7'h7f;
            2'h1: return (hm || v == fpw_pkg::FPW_V16K) ? 7'h00 : 7'h7e;
            2'h0: return (v == fpw_pkg::FPW_V32KE) ? 7'h00 : 7'h7d;
            default: case (v)
                fpw_pkg::FPW_V16K: return {sel[0], 6'h3f};
                fpw_pkg::FPW_V32KE, fpw_pkg::FPW_V32KO: return {1'b1, sel[0] ? 6'h3f : 6'h3e};
                fpw_pkg::FPW_V64K: return {sel[2], 3'h7, sel[2:0]};
                fpw_pkg::FPW_V96K: return {|sel[2:1], 3'h7, sel[2:0]};
                default: return {1'b1, 3'h7, sel[2:0]};
            endcase
        endcase
    endfunction
    task automatic cmp(logic [20:0] got, logic [20:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One access; a miss is judged on the hit flag alone
    task automatic acc(logic [15:0] a);
        logic [6:0] e;
        addr = a;
        e = exp_f(a[15:14]);
        @(negedge clk);
        cmp(e[6] ? req : {req.hit, 20'h0}, e[6] ? {e, a[13:0]} : 21'h0);
        if (e[6]) begin
            @(negedge clk);
            cmp(21'(flash_data), 21'({e[1:0], a[13:0]}));
        end
    endtask
    task automatic load(logic [5:0] s);
        we = 1;
        data = s;
        @(negedge clk);
        we = 0;
        sel = s;
        cmp(21'(sel_q), 21'(s));
    endtask
    task automatic t_fixed;
        valid = 1;
        for (int i = 0; i < 6; i++) begin
            v = fpw_pkg::fpw_variant_t'(i);
            for (int k = 0; k < 4; k++) begin
                {en, hm} = 2'(k);
                acc(16'h0123);
                acc(16'h4567);
                acc(16'hfedc);
            end
        end
        $display("t_fixed done");
    endtask
    // Load then access at once, every alias pattern per variant
    task automatic t_paged;
        en = 1;
        for (int i = 0; i < 6; i++) begin
            v = fpw_pkg::fpw_variant_t'(i);
            for (int j = 0; j < 8; j++) begin
                load(6'(j * 9));
                acc(16'h8000 + 16'(j * 1111));
            end
        end
        valid = 0;
        acc(16'hc000);
        $display("t_paged done");
    endtask
    task automatic test_done;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst = 0;
        cmp(21'(sel_q), 21'h0);
        cmp(req, 21'h0);
        $display("t_reset done");
        t_fixed;
        t_paged;
        test_done;
    end
endmodule // fpw_mapper_test
